// File: hw_mode_pkg.sv
// Purpose: constants, types and carriers of the hardware-mode strap and status logic
// Assumes: one clock (hclk, 125 MHz), registers reached over AHB-Lite
// Notes: strap pins are sampled once after reset release
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package hw_mode_pkg;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam int RATIO_LSB = 0;
    localparam int REF_BIT = 2;
    localparam logic [1:0] RATIO_RST = 2'h0;
    localparam logic [1:0] RATIO_256 = 2'h1;
    localparam logic [1:0] RATIO_512 = 2'h2;
    localparam logic [10:0] MULT_128 = 11'h080;
    localparam logic [10:0] MULT_256 = 11'h100;
    localparam logic [10:0] MULT_512 = 11'h200;
    localparam logic [6:0] BCLK_DIV = 7'h40;
    localparam logic [6:0] NO_DIV = 7'h01;
    localparam logic [1:0] SETTLE_CNT = 2'h2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        PH_HELD = 3'b001,
        PH_SETTLE = 3'b010,
        PH_RUN = 3'b100
    } phase_e;

    typedef struct packed {
        logic receiver_error_pin;
        logic validity_audio_pin;
        logic mclk_out_pin;
        logic chan_status_pin;
        logic passthru_user_pin;
        logic port1_serial_data;
        logic recovered_master_clock;
    } strap_s;

    typedef struct packed {
        strap_s strap;
        logic tx_select;
        logic rx_select;
        logic output_format_strap;
        logic port_role_strap;
        logic [1:0] rx_in;
        logic port2_frame_clock;
        logic crystal_input;
    } pin_in_s;

    typedef struct packed {
        logic nonvalid_qualified_error;
        logic plain_receive_fault;
        logic pcm_audio;
        logic cs_bit;
        logic user_bit;
        logic val_bit;
        logic subframe_stb;
        logic z_preamble;
        logic src_locked;
        logic port1_data;
        logic pll_clock;
    } core_in_s;

    typedef struct packed {
        logic hw_mode;
        logic src_clk_pll;
        logic port1_clk_recovered;
        logic deemph_auto;
        logic out_format;
        logic port_role_master;
        logic active_rx;
        logic [10:0] recovered_master_clock_mult;
        logic [6:0] rate_div;
    } cfg_s;

    typedef struct packed {
        phase_e phase;
        logic [1:0] settle;
        pin_in_s meta;
        pin_in_s sync;
        logic lrck_d;
        strap_s strap;
        logic fmt;
        logic role;
        logic cs_hold;
        logic user_hold;
        logic val_hold;
        logic cs_ser;
        logic user_ser;
        logic val_ser;
        logic seen_z;
        logic blk;
        logic lock_lost;
        logic [1:0] ratio;
        logic ref_bclk;
        logic dp_wr;
        logic [11:0] dp_addr;
        logic [31:0] rdata;
        strap_s pout;
        cfg_s cfg;
    } st_s;
endpackage

// File: hw_mode_ctrl.sv
// Purpose: strap capture, status pins and bit serialisation in hardware mode
// Assumes: pins and frame clock are asynchronous; core_in is on hclk
// Notes: clocks are repeated at hclk rate, so only slow clocks pass cleanly
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module hw_mode_ctrl
    import hw_mode_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pin_in_s pins_in,
    input wire core_in_s core_in,
    output strap_s pins_out,
    output strap_s pins_oe,
    output cfg_s cfg,
    output logic block_start_flag,
    output logic converter_lock_lost,
    output logic low_power
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [10:0] mult_of(input logic [1:0] r);
        case (r)
            RATIO_256: mult_of = MULT_256;
            RATIO_512: mult_of = MULT_512;
            default: mult_of = MULT_128;
        endcase
    endfunction

    st_s st_r;
    st_s st_nxt;
    logic acc;
    logic edge2;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        acc = hsel & hready & htrans[1];
        // first stage feeds only the second
        st_nxt.meta = pins_in;
        st_nxt.sync = st_r.meta;
        st_nxt.lrck_d = st_r.sync.port2_frame_clock;
        // edges only count in run phase: reset zeros in the sync chain are no edge
        edge2 = (st_r.phase == PH_RUN) & (st_r.sync.port2_frame_clock ^ st_r.lrck_d);

        // strap phase: pins float until straps are caught
        case (st_r.phase)
            PH_HELD: begin
                st_nxt.phase = PH_SETTLE;
                st_nxt.settle = 2'h0;
            end
            PH_SETTLE: begin
                st_nxt.settle = 2'(st_r.settle + 2'h1);
                if (st_r.settle == SETTLE_CNT) begin
                    // wait lets the synchroniser show the strap, not reset junk
                    st_nxt.strap = st_r.sync.strap;
                    st_nxt.fmt = st_r.sync.output_format_strap;
                    st_nxt.role = st_r.sync.port_role_strap;
                    st_nxt.phase = PH_RUN;
                end
            end
            PH_RUN: begin
                st_nxt.phase = PH_RUN;
            end
            default: begin
                st_nxt.phase = PH_HELD;
            end
        endcase

        // receiver bits captured per subframe
        if (core_in.subframe_stb) begin
            st_nxt.cs_hold = core_in.cs_bit;
            st_nxt.user_hold = core_in.user_bit;
            st_nxt.val_hold = core_in.val_bit;
            if (core_in.z_preamble) begin
                st_nxt.seen_z = 1'b1;
                st_nxt.blk = 1'b1;
            end else begin
                st_nxt.blk = 1'b0;
            end
        end

        // both frame-2 clock edges advance the serial bits
        if (edge2) begin
            st_nxt.cs_ser = st_r.cs_hold;
            st_nxt.user_ser = st_r.user_hold;
            st_nxt.val_ser = st_r.val_hold;
        end

        st_nxt.lock_lost = ~core_in.src_locked;

        // ahb write data phase
        st_nxt.dp_wr = 1'b0;
        if (st_r.dp_wr && hit(st_r.dp_addr, CTRL_OFS)) begin
            st_nxt.ratio = hwdata[RATIO_LSB +: 2];
            st_nxt.ref_bclk = hwdata[REF_BIT];
        end
        if (acc) begin
            st_nxt.dp_wr = hwrite;
            st_nxt.dp_addr = haddr[11:0];
        end
        // reads see a write made just before them
        if (acc && !hwrite) begin
            if (hit(haddr[11:0], CTRL_OFS)) begin
                st_nxt.rdata = ZERO_WORD;
                st_nxt.rdata[RATIO_LSB +: 2] = st_nxt.ratio;
                st_nxt.rdata[REF_BIT] = st_nxt.ref_bclk;
            end else if (hit(haddr[11:0], STATUS_OFS)) begin
                st_nxt.rdata = {17'h0_0000, st_r.lock_lost, st_r.seen_z,
                    st_r.blk, st_r.role, st_r.fmt, st_r.strap, st_r.phase};
            end else begin
                st_nxt.rdata = ZERO_WORD;
            end
        end

        // pins and configuration
        st_nxt.pout = '0;
        if (st_r.phase == PH_RUN) begin
            st_nxt.pout.receiver_error_pin = st_r.strap.receiver_error_pin ?
                core_in.plain_receive_fault :
                core_in.nonvalid_qualified_error;
            st_nxt.pout.validity_audio_pin = st_r.strap.validity_audio_pin ?
                ~core_in.pcm_audio : st_r.val_ser;
            st_nxt.pout.mclk_out_pin = st_r.sync.crystal_input;
            st_nxt.pout.chan_status_pin = st_r.cs_ser;
            st_nxt.pout.passthru_user_pin = st_r.strap.passthru_user_pin ?
                st_r.user_ser :
                st_r.sync.rx_in[st_r.sync.tx_select];
            st_nxt.pout.port1_serial_data = core_in.port1_data;
            st_nxt.pout.recovered_master_clock = core_in.pll_clock;
        end
        st_nxt.cfg.hw_mode = st_r.strap.chan_status_pin;
        st_nxt.cfg.src_clk_pll = st_r.strap.mclk_out_pin;
        st_nxt.cfg.port1_clk_recovered = st_r.strap.recovered_master_clock;
        st_nxt.cfg.deemph_auto = ~st_r.strap.port1_serial_data;
        st_nxt.cfg.out_format = st_r.fmt;
        st_nxt.cfg.port_role_master = st_r.role;
        st_nxt.cfg.active_rx = st_r.sync.rx_in[st_r.sync.rx_select];
        st_nxt.cfg.recovered_master_clock_mult = mult_of(st_r.ratio);
        st_nxt.cfg.rate_div = st_r.ref_bclk ? BCLK_DIV : NO_DIV;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.phase <= PH_HELD;
            st_r.ratio <= RATIO_RST;
            st_r.cfg.rate_div <= NO_DIV;
            st_r.cfg.recovered_master_clock_mult <= MULT_128;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign pins_out = st_r.pout;
    // driven only after straps are caught, so the pull resistor is read clean
    assign pins_oe = (st_r.phase == PH_RUN) ? '1 : '0;
    assign cfg = st_r.cfg;
    assign block_start_flag = st_r.blk;
    assign converter_lock_lost = st_r.lock_lost;
    assign low_power = (st_r.phase != PH_RUN);
endmodule // hw_mode_ctrl

// File: hw_mode_assertions.sv
// Purpose: port checker of hw_mode_ctrl
// Assumes: one clock domain, hclk
// Notes: bound to every hw_mode_ctrl instance
`timescale 1ns/100ps
module hw_mode_assertions
    import hw_mode_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire pin_in_s pins_in,
    input wire core_in_s core_in,
    input wire strap_s pins_out,
    input wire strap_s pins_oe,
    input wire cfg_s cfg,
    input wire logic block_start_flag,
    input wire logic converter_lock_lost,
    input wire logic low_power
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
    a_lock_follow: assert property (
        $past(hresetn) |-> converter_lock_lost == !$past(core_in.src_locked))
        else $error("unlock flag wrong");
    a_pins_idle: assert property (
        pins_oe == (low_power ? 7'h00 : 7'h7f)) else $error("pins driven in low power");
    a_strap_hold: assert property (
        !low_power && !$past(low_power) |=> $stable({cfg.hw_mode, cfg.src_clk_pll,
        cfg.port1_clk_recovered, cfg.deemph_auto, cfg.out_format, cfg.port_role_master}))
        else $error("strap setting moved");
    a_blk_set: assert property (
        !low_power && core_in.subframe_stb && core_in.z_preamble |=> block_start_flag)
        else $error("block flag missed");
    a_blk_clear: assert property (
        block_start_flag && core_in.subframe_stb && !core_in.z_preamble
        |=> !block_start_flag) else $error("block flag too long");
    a_blk_hold: assert property (
        !core_in.subframe_stb |=> $stable(block_start_flag)) else $error("flag moved");
    a_cs_step: assert property (
        (!low_power && $stable(pins_in.port2_frame_clock))[*6]
        |=> $stable(pins_out.chan_status_pin)) else $error("status bit off frame edge");
endmodule // hw_mode_assertions

bind hw_mode_ctrl hw_mode_assertions chk (.hclk, .hresetn, .hreadyout, .hresp, .pins_in,
    .core_in, .pins_out, .pins_oe, .cfg, .block_start_flag, .converter_lock_lost,
    .low_power);

// File: hw_mode_board.sv
// Purpose: board resistors on the strap pins
// Assumes: each strap pin has a pull-up or a pull-down
// Notes: a released pin shows its resistor level
`timescale 1ns/100ps
module hw_mode_board
    import hw_mode_pkg::*;
(
    input wire strap_s pull_up,
    input wire strap_s drive,
    input wire strap_s drive_en,
    output strap_s level
);
    assign level = (drive & drive_en) | (pull_up & ~drive_en);
endmodule // hw_mode_board

// File: tb_top.sv
// Purpose: self-checking bench of hw_mode_ctrl
// Assumes: 125 MHz hclk, random straps from seed 75
// Notes: expectations follow the strap table, not the design
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top;
    import hw_mode_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, x;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic block_start_flag, converter_lock_lost, low_power;
    pin_in_s pi, pin_w;
    core_in_s ci;
    strap_s pull, pins_out, pins_oe, lvl;
    cfg_s cfg;
    int bad_count, n_compared, seed, m, model_q[$];
    assign pin_w = {lvl, pi[7:0]};
    hw_mode_board board (.pull_up(pull), .drive(pins_out), .drive_en(pins_oe), .level(lvl));
    hw_mode_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pins_in(pin_w),
        .core_in(ci), .pins_out, .pins_oe, .cfg, .block_start_flag, .converter_lock_lost,
        .low_power);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic boot();
        @(posedge hclk);
        hresetn <= 1'b0;
        {pull, pi.output_format_strap, pi.port_role_strap} <= 9'($random(seed));
        repeat (10) @(posedge hclk);
        `CHK({low_power, pins_oe}, 8'h80)
        hresetn <= 1'b1;
        repeat (8) @(negedge hclk);
        `CHK(cfg.hw_mode, pull.chan_status_pin)
        `CHK(cfg.src_clk_pll, pull.mclk_out_pin)
        `CHK(cfg.port1_clk_recovered, pull.recovered_master_clock)
        `CHK(cfg.deemph_auto, !pull.port1_serial_data)
        `CHK(cfg.out_format, pi.output_format_strap)
        `CHK(cfg.port_role_master, pi.port_role_strap)
        @(posedge hclk);
        pi.output_format_strap <= !pi.output_format_strap;
        repeat (6) @(negedge hclk);
        `CHK(cfg.out_format, !pi.output_format_strap)
    endtask
    // random core levels with no strobe; one subframe strobe per pass
    task automatic work();
        for (int k = 0; k < 8; k++) begin
            @(posedge hclk);
            ci <= core_in_s'(11'($random(seed)) & 11'h7ef);
            {pi.tx_select, pi.rx_select, pi.rx_in, pi.crystal_input} <= 5'($random(seed));
            repeat (5) @(negedge hclk);
            `CHK(converter_lock_lost, !ci.src_locked)
            `CHK(cfg.active_rx, pi.rx_in[pi.rx_select])
            `CHK(pins_out.mclk_out_pin, pi.crystal_input)
            `CHK(pins_out.recovered_master_clock, ci.pll_clock)
            `CHK(pins_out.port1_serial_data, ci.port1_data)
            x = pull.receiver_error_pin ? ci.plain_receive_fault : ci.nonvalid_qualified_error;
            `CHK(pins_out.receiver_error_pin, x)
            if (pull.validity_audio_pin) `CHK(pins_out.validity_audio_pin, !ci.pcm_audio)
            x = pi.rx_in[pi.tx_select];
            if (!pull.passthru_user_pin) `CHK(pins_out.passthru_user_pin, x)
            @(posedge hclk);
            ci.subframe_stb <= 1'b1;
            model_q.push_back({ci.z_preamble, ci.cs_bit, ci.user_bit, ci.val_bit});
            @(posedge hclk);
            ci.subframe_stb <= 1'b0;
            pi.port2_frame_clock <= !pi.port2_frame_clock;
            repeat (8) @(negedge hclk);
            m = model_q.pop_front();
            `CHK(block_start_flag, m[3])
            `CHK(pins_out.chan_status_pin, m[2])
            if (pull.passthru_user_pin) `CHK(pins_out.passthru_user_pin, m[1])
            if (!pull.validity_audio_pin) `CHK(pins_out.validity_audio_pin, m[0])
        end
    endtask
    task automatic conclude();
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // run
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    initial begin
        seed = 75;
        bad_count = 0;
        n_compared = 0;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        pi = '0;
        ci = '0;
        pull = '0;
        repeat (4) begin
            boot();
            work();
        end
        // ratio codes with and without the bit-clock reference
        for (int r = 0; r < 8; r++) begin
            ahb(1'b1, 32'h0000_0000, 32'(r));
            ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
            `CHK(rd[2:0], 3'(r))
            repeat (2) @(negedge hclk);
            m = (r % 4 == 1) ? 256 : (r % 4 == 2) ? 512 : 128;
            `CHK(cfg.recovered_master_clock_mult, 11'(m))
            `CHK(cfg.rate_div, (r > 3) ? BCLK_DIV : NO_DIV)
        end
        ahb(1'b1, 32'h0000_0010, 32'h0000_00ff);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        `CHK(rd, ZERO_WORD)
        ahb(1'b0, 32'h0000_0004, ZERO_WORD);
        `CHK(rd[11:0], {pi.port_role_strap, !pi.output_format_strap, pull, 3'h4})
        `CHK({rd[31:15], rd[12]}, {17'h0_0000, ci.z_preamble})
        `CHK(rd[14], !ci.src_locked)
        conclude();
    end
endmodule // tb_top
